// *** hdl/tpfa_top.sv ***
// table pointer / table latch flash access unit
`timescale 1ns/1ps
`default_nettype none
module tpfa_top
   import tpfa_pkg::*;
(
   // clocking
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   // core register file port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // table instruction port
   input  wire logic        tbl_req,
   input  wire logic        tbl_write,
   input  wire logic [1:0]  tbl_mode,
   output logic             tbl_done,
   output logic             core_stall,
   // program flash array
   output logic             fl_rd,
   output logic             fl_cfg,
   output logic [21:0]      fl_addr,
   input  wire logic [7:0]  fl_rdata,
   input  wire logic        fl_rvalid,
   output logic             fl_prog,
   output logic             fl_erase,
   output logic [63:0]      fl_wdata,
   output logic             fl_busy
);
   // pointer step limited to the low 21 bits
   function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic down);
      logic [20:0] lo;
      lo = down ? (p[20:0] - 21'h000001) : (p[20:0] + 21'h000001);
      return {p[21], lo};
   endfunction

   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] r);
      return (a == r);
   endfunction

   logic [7:0]  latch_r, latch_nxt;
   logic [21:0] ptr_r, ptr_nxt;
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  hold_r [TPFA_HOLD_N];
   logic [7:0]  hold_nxt [TPFA_HOLD_N];
   logic [15:0] cnt_r, cnt_nxt;
   logic        erase_r, erase_nxt;
   logic        cfg_r, cfg_nxt;
   logic [21:0] op_addr_r, op_addr_nxt;
   logic        post_r, post_nxt;
   logic        down_r, down_nxt;
   tpfa_sq_t    sq_r, sq_nxt;
   logic        unlocked;
   logic        start_req;
   tpfa_op_t    mode;
   logic        wr_latch;
   logic        wr_ptr_l;
   logic        wr_ptr_h;
   logic        wr_ptr_u;
   logic        wr_ctrl;
   logic        tbl_take;
   logic        pre_inc;
   logic        post_any;
   logic [2:0]  hold_sel;
   logic        prog_end;

   tpfa_unlock u_unlock (
      .clk      (clk),
      .nrst     (nrst),
      .ce       (ce),
      .wr_en    (reg_wr),
      .wr_addr  (reg_addr),
      .wr_data  (reg_wdata),
      .unlocked (unlocked)
   );

   assign mode = tpfa_op_t'(tbl_mode);

   // software writes only land while the sequencer is idle
   assign wr_latch = reg_wr && (sq_r == TPFA_SQ_IDLE) && is_reg(reg_addr, TPFA_ADDR_LATCH);
   assign wr_ptr_l = reg_wr && (sq_r == TPFA_SQ_IDLE) && is_reg(reg_addr, TPFA_ADDR_PTR_L);
   assign wr_ptr_h = reg_wr && (sq_r == TPFA_SQ_IDLE) && is_reg(reg_addr, TPFA_ADDR_PTR_H);
   assign wr_ptr_u = reg_wr && (sq_r == TPFA_SQ_IDLE) && is_reg(reg_addr, TPFA_ADDR_PTR_U);
   assign wr_ctrl  = reg_wr && (sq_r == TPFA_SQ_IDLE) && is_reg(reg_addr, TPFA_ADDR_CTRL);
   // a start write wins over a table request in the same cycle
   assign tbl_take = tbl_req && !start_req && (sq_r == TPFA_SQ_IDLE);
   assign pre_inc  = (mode == TPFA_OP_PREINC);
   assign post_any = (mode == TPFA_OP_POSTINC) || (mode == TPFA_OP_POSTDEC);
   // pre-increment write lands in the slot of the incremented pointer; carry out of bit 2 is dropped on purpose
   assign hold_sel = ptr_r[2:0] + {2'b00, pre_inc};
   assign prog_end = (sq_r == TPFA_SQ_ARRAY) && (cnt_r == 16'h0001);

   // start only counts when permitted, unlocked and the core is idle
   assign start_req = reg_wr && is_reg(reg_addr, TPFA_ADDR_CTRL) && reg_wdata[TPFA_BIT_WR]
                      && !ctrl_r[TPFA_BIT_WR] && unlocked
                      && ctrl_r[TPFA_BIT_WEN] && reg_wdata[TPFA_BIT_WEN]
                      && (sq_r == TPFA_SQ_IDLE);

   always_comb begin
      latch_nxt   = latch_r;
      ctrl_nxt    = ctrl_r;
      cnt_nxt     = cnt_r;
      erase_nxt   = erase_r;
      cfg_nxt     = cfg_r;
      op_addr_nxt = op_addr_r;
      post_nxt    = post_r;
      down_nxt    = down_r;
      sq_nxt      = sq_r;
      // software register writes
      if (wr_latch) latch_nxt = reg_wdata;
      if (wr_ctrl) begin
         ctrl_nxt[TPFA_BIT_PGD]  = reg_wdata[TPFA_BIT_PGD];
         ctrl_nxt[TPFA_BIT_CONFIG_SPACE_SELECT] = reg_wdata[TPFA_BIT_CONFIG_SPACE_SELECT];
         ctrl_nxt[TPFA_BIT_FREE] = reg_wdata[TPFA_BIT_FREE];
         ctrl_nxt[TPFA_BIT_WEN]  = reg_wdata[TPFA_BIT_WEN];
         // error flag is clear-only from software
         if (!reg_wdata[TPFA_BIT_ERR]) ctrl_nxt[TPFA_BIT_ERR] = 1'b0;
      end
      case (sq_r)
         TPFA_SQ_IDLE: begin
            if (start_req) begin
               ctrl_nxt[TPFA_BIT_WR] = 1'b1;
               erase_nxt = reg_wdata[TPFA_BIT_FREE];
               cfg_nxt   = reg_wdata[TPFA_BIT_CONFIG_SPACE_SELECT] || !reg_wdata[TPFA_BIT_PGD];
               if (reg_wdata[TPFA_BIT_FREE]) begin
                  op_addr_nxt = {ptr_r[21:TPFA_ERASE_LSB], 6'h00};
               end else begin
                  op_addr_nxt = {ptr_r[21:TPFA_ROW_LSB], 3'h0};
               end
               cnt_nxt = TPFA_PROG_CYC16;
               sq_nxt  = TPFA_SQ_ARRAY;
            end else if (tbl_req) begin
               post_nxt = (mode == TPFA_OP_POSTINC) || (mode == TPFA_OP_POSTDEC);
               down_nxt = (mode == TPFA_OP_POSTDEC);
               op_addr_nxt = pre_inc ? ptr_step(ptr_r, 1'b0) : ptr_r;
               if (tbl_write) begin
                  sq_nxt = TPFA_SQ_DONE;
               end else begin
                  sq_nxt = TPFA_SQ_READ;
               end
            end
         end
         TPFA_SQ_READ: begin
            if (fl_rvalid) begin
               latch_nxt = fl_rdata;
               sq_nxt = TPFA_SQ_DONE;
            end
         end
         TPFA_SQ_ARRAY: begin
            if (cnt_r == 16'h0001) begin
               ctrl_nxt[TPFA_BIT_WR] = 1'b0;
               ctrl_nxt[TPFA_BIT_WEN] = ctrl_r[TPFA_BIT_WEN];
               sq_nxt = TPFA_SQ_IDLE;
            end
            cnt_nxt = cnt_r - 16'h0001;
         end
         TPFA_SQ_DONE: sq_nxt = TPFA_SQ_IDLE;
         default:      sq_nxt = TPFA_SQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch_r   <= TPFA_LATCH_RST;
         ctrl_r    <= TPFA_CTRL_RST;
         cnt_r     <= 16'h0000;
         erase_r   <= 1'b0;
         cfg_r     <= 1'b0;
         op_addr_r <= TPFA_PTR_RST;
         post_r    <= 1'b0;
         down_r    <= 1'b0;
         sq_r      <= TPFA_SQ_IDLE;
      end else if (ce) begin
         latch_r   <= latch_nxt;
         ctrl_r    <= ctrl_nxt;
         cnt_r     <= cnt_nxt;
         erase_r   <= erase_nxt;
         cfg_r     <= cfg_nxt;
         op_addr_r <= op_addr_nxt;
         post_r    <= post_nxt;
         down_r    <= down_nxt;
         sq_r      <= sq_nxt;
      end
   end

   // pointer: byte writes from software, steps from table operations
   always_comb begin
      ptr_nxt = ptr_r;
      if (wr_ptr_l) ptr_nxt[7:0] = reg_wdata;
      if (wr_ptr_h) ptr_nxt[15:8] = reg_wdata;
      if (wr_ptr_u) ptr_nxt[21:16] = reg_wdata[5:0];
      if (tbl_take && pre_inc) begin
         ptr_nxt = ptr_step(ptr_r, 1'b0);
      end
      if (tbl_take && tbl_write && post_any) begin
         ptr_nxt = ptr_step(ptr_r, mode == TPFA_OP_POSTDEC);
      end
      if ((sq_r == TPFA_SQ_READ) && fl_rvalid && post_r) begin
         ptr_nxt = ptr_step(ptr_r, down_r);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_r <= TPFA_PTR_RST;
      end else if (ce) begin
         ptr_r <= ptr_nxt;
      end
   end

   // holding registers return to the erased value after programming so stale bytes are never reused
   always_comb begin
      for (int i = 0; i < TPFA_HOLD_N; i++) begin
         hold_nxt[i] = hold_r[i];
      end
      if (tbl_take && tbl_write) begin
         hold_nxt[hold_sel] = latch_r;
      end
      if (prog_end && !erase_r) begin
         for (int i = 0; i < TPFA_HOLD_N; i++) begin
            hold_nxt[i] = TPFA_HOLD_RST;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < TPFA_HOLD_N; i++) begin
            hold_r[i] <= TPFA_HOLD_RST;
         end
      end else if (ce) begin
         for (int i = 0; i < TPFA_HOLD_N; i++) begin
            hold_r[i] <= hold_nxt[i];
         end
      end
   end

   // register read mux; unmapped addresses read zero
   always_comb begin
      reg_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            TPFA_ADDR_LATCH: reg_rdata = latch_r;
            TPFA_ADDR_PTR_L: reg_rdata = ptr_r[7:0];
            TPFA_ADDR_PTR_H: reg_rdata = ptr_r[15:8];
            TPFA_ADDR_PTR_U: reg_rdata = {2'b00, ptr_r[21:16]};
            TPFA_ADDR_CTRL:  reg_rdata = {ctrl_r[7:6], 1'b0, ctrl_r[4:0]};
            default:         reg_rdata = 8'h00; // unlock port has no storage
         endcase
      end
   end

   // flash array side
   assign fl_rd      = (sq_r == TPFA_SQ_READ);
   assign fl_cfg     = (sq_r == TPFA_SQ_ARRAY) ? cfg_r : op_addr_r[21];
   assign fl_addr    = op_addr_r;
   assign fl_busy    = (sq_r == TPFA_SQ_ARRAY);
   assign fl_erase   = fl_busy && erase_r;
   assign fl_prog    = fl_busy && !erase_r;
   assign fl_wdata   = {hold_r[7], hold_r[6], hold_r[5], hold_r[4],
                        hold_r[3], hold_r[2], hold_r[1], hold_r[0]};
   assign core_stall = (sq_r == TPFA_SQ_ARRAY) || (sq_r == TPFA_SQ_READ);
   assign tbl_done   = (sq_r == TPFA_SQ_DONE);
endmodule
`default_nettype wire

// *** include/tpfa_pkg.sv ***
// package of constants and types for the table pointer flash access unit
package tpfa_pkg;
   // special function register addresses (core register file, 12-bit space)
   localparam logic [11:0] TPFA_ADDR_LATCH = 12'hFF5;
   localparam logic [11:0] TPFA_ADDR_PTR_L = 12'hFF6;
   localparam logic [11:0] TPFA_ADDR_PTR_H = 12'hFF7;
   localparam logic [11:0] TPFA_ADDR_PTR_U = 12'hFF8;
   localparam logic [11:0] TPFA_ADDR_CTRL  = 12'hFA6;
   localparam logic [11:0] TPFA_ADDR_UNLK  = 12'hFA7;
   // memory_access_control bit positions
   localparam int TPFA_BIT_PGD  = 7;
   localparam int TPFA_BIT_CONFIG_SPACE_SELECT = 6;
   localparam int TPFA_BIT_FREE = 4;
   localparam int TPFA_BIT_ERR  = 3;
   localparam int TPFA_BIT_WEN  = 2;
   localparam int TPFA_BIT_WR   = 1;
   localparam int TPFA_BIT_RD   = 0;
   // reset values
   localparam logic [7:0]  TPFA_CTRL_RST  = 8'h00;
   localparam logic [7:0]  TPFA_LATCH_RST = 8'h00;
   localparam logic [21:0] TPFA_PTR_RST   = 22'h000000;
   localparam logic [7:0]  TPFA_HOLD_RST  = 8'hFF;
   // unlock keys
   localparam logic [7:0]  TPFA_KEY1 = 8'h55;
   localparam logic [7:0]  TPFA_KEY2 = 8'hAA;
   // pointer geometry
   localparam int TPFA_PTR_W     = 22;
   localparam int TPFA_ROW_LSB   = 3;
   localparam int TPFA_ERASE_LSB = 6;
   localparam int TPFA_HOLD_N    = 8;
   // timed operation length
   localparam int TPFA_CLK_MHZ      = 100;
   localparam int TPFA_PROG_TIME_US = 2;
   localparam int TPFA_PROG_CYC     = TPFA_PROG_TIME_US * TPFA_CLK_MHZ;
   localparam logic [15:0] TPFA_PROG_CYC16 = 16'(TPFA_PROG_CYC);
   // table op variants
   typedef enum logic [1:0] {
      TPFA_OP_PLAIN   = 2'h0,
      TPFA_OP_POSTINC = 2'h1,
      TPFA_OP_POSTDEC = 2'h2,
      TPFA_OP_PREINC  = 2'h3
   } tpfa_op_t;
   // unlock tracker
   typedef enum logic [2:0] {
      TPFA_UL_IDLE = 3'b001,
      TPFA_UL_KEY1 = 3'b010,
      TPFA_UL_OPEN = 3'b100
   } tpfa_ul_t;
   // main sequencer
   typedef enum logic [3:0] {
      TPFA_SQ_IDLE  = 4'b0001,
      TPFA_SQ_READ  = 4'b0010,
      TPFA_SQ_ARRAY = 4'b0100,
      TPFA_SQ_DONE  = 4'b1000
   } tpfa_sq_t;
endpackage

// *** hdl/tpfa_unlock.sv ***
// unlock sequence tracker for the flash start bit
`timescale 1ns/1ps
`default_nettype none
module tpfa_unlock
   import tpfa_pkg::*;
(
   // clocking
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   // register write strobe
   input  wire logic       wr_en,
   input  wire logic [11:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // result
   output logic            unlocked
);
   tpfa_ul_t st_r;
   tpfa_ul_t st_nxt;

   // any write other than the expected key breaks the sequence; a repeated first key leaves it waiting for the second
   always_comb begin
      st_nxt = st_r;
      if (wr_en) begin
         case (st_r)
            TPFA_UL_IDLE: st_nxt = (wr_addr == TPFA_ADDR_UNLK && wr_data == TPFA_KEY1) ? TPFA_UL_KEY1 : TPFA_UL_IDLE;
            TPFA_UL_KEY1: st_nxt = (wr_addr == TPFA_ADDR_UNLK && wr_data == TPFA_KEY2) ? TPFA_UL_OPEN :
                                   (wr_addr == TPFA_ADDR_UNLK && wr_data == TPFA_KEY1) ? TPFA_UL_KEY1 : TPFA_UL_IDLE;
            TPFA_UL_OPEN: st_nxt = (wr_addr == TPFA_ADDR_UNLK && wr_data == TPFA_KEY1) ? TPFA_UL_KEY1 : TPFA_UL_IDLE;
            default:      st_nxt = TPFA_UL_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= TPFA_UL_IDLE;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign unlocked = (st_r == TPFA_UL_OPEN);
endmodule
`default_nettype wire

// *** test/tpfa_assertions.sv ***
// port assertions for the table pointer flash access unit
`timescale 1ns/1ps
`default_nettype none
module tpfa_assertions
   import tpfa_pkg::*;
(
   // clocking
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   // register port
   input wire logic        reg_wr,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   // table port
   input wire logic        tbl_req,
   input wire logic        tbl_write,
   input wire logic        tbl_done,
   input wire logic        core_stall,
   // flash side
   input wire logic        fl_rd,
   input wire logic        fl_cfg,
   input wire logic [21:0] fl_addr,
   input wire logic        fl_rvalid,
   input wire logic        fl_prog,
   input wire logic        fl_erase,
   input wire logic        fl_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [15:0] busy_cnt_r;
   logic [15:0] busy_cnt_nxt;
   logic        idle;
   assign idle = !core_stall && !tbl_done;
   // count freezes with the clock enable, as the design's timer does
   always_comb begin
      busy_cnt_nxt = !fl_busy ? 16'h0000 : (ce ? busy_cnt_r + 16'h0001 : busy_cnt_r);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_cnt_r <= 16'h0000;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end
   a_stall_while_busy: assert property (fl_busy |-> core_stall)
      else $error("core runs during flash operation");
   a_one_timed_op: assert property (fl_busy == (fl_prog ^ fl_erase))
      else $error("program and erase not exclusive");
   a_busy_length_exact: assert property ($fell(fl_busy) |-> busy_cnt_r == TPFA_PROG_CYC16)
      else $error("timed operation length wrong");
   a_start_needs_permit: assert property ($rose(fl_busy) |-> $past(ce && reg_wr && reg_addr == TPFA_ADDR_CTRL
      && reg_wdata[TPFA_BIT_WEN] && reg_wdata[TPFA_BIT_WR]))
      else $error("flash operation without permitted start");
   a_cfg_from_top: assert property (fl_rd |-> fl_cfg == fl_addr[21])
      else $error("space select differs from pointer top bit");
   a_read_answer: assert property (ce && fl_rd && fl_rvalid |=> tbl_done ##1 !tbl_done)
      else $error("read completion missing");
   a_write_done: assert property (ce && tbl_req && tbl_write && idle |=> tbl_done && !core_stall)
      else $error("table write not done next cycle");
   a_read_launch: assert property (ce && tbl_req && !tbl_write && idle |=> fl_rd && core_stall)
      else $error("table read not launched");
   a_done_single: assert property (ce && tbl_done |=> !tbl_done)
      else $error("done longer than one cycle");
endmodule
bind tpfa_top tpfa_assertions tpfa_assertions_inst (.*);
`default_nettype wire

// *** test/tpfa_flash_model.sv ***
// behavioural program flash array answering table reads
`timescale 1ns/1ps
`default_nettype none
module tpfa_flash_model (
   // clocking
   input  wire logic        clk,
   input  wire logic        nrst,
   // read request
   input  wire logic        fl_rd,
   input  wire logic        fl_cfg,
   input  wire logic [21:0] fl_addr,
   input  wire logic        slow,
   // answer
   output logic [7:0]       fl_rdata,
   output logic             fl_rvalid
);
   logic [2:0] wait_r;
   logic       got_r;
   logic       fire;
   assign fire = fl_rd && !got_r && wait_r == (slow ? 3'h5 : 3'h0);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_r    <= 3'h0;
         got_r     <= 1'b0;
         fl_rvalid <= 1'b0;
         fl_rdata  <= 8'h00;
      end else begin
         fl_rvalid <= fire;
         got_r     <= fl_rd && (got_r || fire);
         wait_r    <= (fl_rd && !got_r) ? wait_r + 3'h1 : 3'h0;
         // data only valid with the strobe; otherwise it keeps toggling
         fl_rdata  <= fire ? fl_addr[7:0] ^ (fl_cfg ? 8'hC3 : 8'h3C) : ~fl_rdata;
      end
   end
endmodule
`default_nettype wire

// *** test/test_tpfa_top.sv ***
// self-checking testbench of the table pointer flash access unit
`timescale 1ns/1ps
`default_nettype none
module test_tpfa_top;
   import tpfa_pkg::*;
   logic        clk, nrst, ce, reg_wr, reg_rd, tbl_req, tbl_write, slow;
   logic        tbl_done, core_stall, fl_rd, fl_cfg, fl_rvalid, fl_prog, fl_erase, fl_busy;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, fl_rdata;
   logic [1:0]  tbl_mode;
   logic [21:0] fl_addr, p, u;
   logic [63:0] fl_wdata;
   int          num_errors, n_compared, busy_n;
   logic [11:0] addrs [7] = '{TPFA_ADDR_LATCH, TPFA_ADDR_PTR_L, TPFA_ADDR_PTR_H, TPFA_ADDR_PTR_U,
                              TPFA_ADDR_CTRL, TPFA_ADDR_UNLK, 12'h000};
   logic [21:0] pb [3] = '{22'h3FFFFF, 22'h200000, 22'h1FFFFF};
   tpfa_top tpfa_top_inst (.clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tbl_req(tbl_req),
      .tbl_write(tbl_write), .tbl_mode(tbl_mode), .tbl_done(tbl_done), .core_stall(core_stall),
      .fl_rd(fl_rd), .fl_cfg(fl_cfg), .fl_addr(fl_addr), .fl_rdata(fl_rdata), .fl_rvalid(fl_rvalid),
      .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_wdata(fl_wdata), .fl_busy(fl_busy));
   tpfa_flash_model tpfa_flash_model_inst (.clk(clk), .nrst(nrst), .fl_rd(fl_rd), .fl_cfg(fl_cfg),
      .fl_addr(fl_addr), .slow(slow), .fl_rdata(fl_rdata), .fl_rvalid(fl_rvalid));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (fl_busy) busy_n <= busy_n + 1;
   end
   function automatic logic [21:0] nx(input logic [21:0] a, input logic [20:0] d);
      return {a[21], a[20:0] + d};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      chk(reg_rdata, e);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic setp(input logic [21:0] v);
      wr(TPFA_ADDR_PTR_U, {2'b00, v[21:16]});
      wr(TPFA_ADDR_PTR_H, v[15:8]);
      wr(TPFA_ADDR_PTR_L, v[7:0]);
   endtask
   task automatic getp(input logic [21:0] v);
      rd(TPFA_ADDR_PTR_U, {2'b00, v[21:16]});
      rd(TPFA_ADDR_PTR_H, v[15:8]);
      rd(TPFA_ADDR_PTR_L, v[7:0]);
   endtask
   task automatic tbl(input logic w, input logic [1:0] m);
      tbl_req <= 1'b1;
      tbl_write <= w;
      tbl_mode <= m;
      @(posedge clk);
      tbl_req <= 1'b0;
      for (int i = 0; i < 40 && !tbl_done; i++) @(posedge clk);
      chk(tbl_done, 1'b1);
   endtask
   task automatic launch(input logic [7:0] c, input logic [1:0] pe, input logic [21:0] msk,
                         input logic [21:0] ea, input logic [63:0] wd, input int tot);
      // permit and mode go in before the keys: any write between the keys and the start breaks the unlock
      wr(TPFA_ADDR_CTRL, c & 8'hFD);
      wr(TPFA_ADDR_UNLK, TPFA_KEY1);
      wr(TPFA_ADDR_UNLK, TPFA_KEY2);
      wr(TPFA_ADDR_CTRL, c);
      chk({fl_prog, fl_erase, core_stall, fl_cfg}, {pe, 2'b10});
      chk(fl_addr & msk, ea);
      chk(fl_wdata, wd);
      for (int i = 0; i < 300 && fl_busy; i++) @(posedge clk);
      chk(busy_n, tot);
      rd(TPFA_ADDR_CTRL, c & 8'hFD);
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish;
   end
   initial begin
      {nrst, reg_wr, reg_rd, tbl_req, tbl_write, slow} = 6'h00;
      {reg_addr, reg_wdata, tbl_mode} = 22'h000000;
      ce = 1'b1;
      num_errors = 0;
      n_compared = 0;
      busy_n = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      for (int b = 0; b < 3; b++) for (int m = 0; m < 4; m++) begin
         p = pb[b];
         u = (m == 3) ? nx(p, 21'h000001) : p;
         slow <= m[0];
         setp(p);
         tbl(1'b0, 2'(m));
         rd(TPFA_ADDR_LATCH, u[7:0] ^ (u[21] ? 8'hC3 : 8'h3C));
         getp(m == 0 ? p : nx(p, m == 2 ? 21'h1FFFFF : 21'h000001));
      end
      setp(22'h0001F8);
      for (int i = 0; i < 8; i++) begin
         wr(TPFA_ADDR_LATCH, 8'h10 + 8'(i));
         tbl(1'b1, TPFA_OP_POSTINC);
      end
      getp(22'h000200);
      // start without unlock, then unlocked start with permit cleared
      wr(TPFA_ADDR_CTRL, 8'h84);
      wr(TPFA_ADDR_CTRL, 8'h86);
      wr(TPFA_ADDR_UNLK, TPFA_KEY1);
      wr(TPFA_ADDR_UNLK, TPFA_KEY2);
      wr(TPFA_ADDR_CTRL, 8'h82);
      chk(busy_n, 0);
      rd(TPFA_ADDR_CTRL, 8'h80);
      setp(22'h0001FD);
      launch(8'h86, 2'b10, 22'h3FFFF8, 22'h0001F8, 64'h1716151413121110, 200);
      setp(22'h00ABCD);
      launch(8'h96, 2'b01, 22'h3FFFC0, 22'h00ABC0, 64'hFFFFFFFFFFFFFFFF, 400);
      tally_and_finish;
   end
endmodule
`default_nettype wire
